// ---- shared/dsc_pkg.sv ----
// Shared constants and carrier types for the startup configuration block.
package dsc_pkg;

  localparam int unsigned REG_W = 16;

  localparam logic [15:0] ADDR_FEEDBACK_DIV = 16'hF000;
  localparam logic [15:0] ADDR_PRESCALE     = 16'hF001;
  localparam logic [15:0] ADDR_CLK_SELECT   = 16'hF002;
  localparam logic [15:0] ADDR_PLL_RUN      = 16'hF003;
  localparam logic [15:0] ADDR_LOCK_STATUS  = 16'hF004;
  localparam logic [15:0] ADDR_CLK_OUT_CFG  = 16'hF005;
  localparam logic [15:0] ADDR_POWER_A      = 16'hF050;
  localparam logic [15:0] ADDR_POWER_B      = 16'hF051;
  localparam logic [15:0] ADDR_CORE_SLEEP   = 16'hF400;
  localparam logic [15:0] ADDR_LAUNCH_SRC   = 16'hF401;
  localparam logic [15:0] ADDR_RUN_CONTROL  = 16'hF402;
  localparam logic [15:0] ADDR_ENTRY_POINT  = 16'hF404;
  localparam logic [15:0] ADDR_HOLD_RELEASE = 16'hF890;
  localparam logic [15:0] ADDR_PAGE_SELECT  = 16'hF899;

  // Addresses below this reach program and data memory.
  localparam logic [15:0] ADDR_REG_BASE     = 16'hF000;
  localparam logic [15:0] ADDR_PROG_MEM     = 16'hC000;
  localparam logic [15:0] ADDR_DATA_MEM0    = 16'h0000;
  localparam logic [15:0] ADDR_DATA_MEM1    = 16'h6000;

  localparam logic [15:0] FEEDBACK_DIV_RST  = 16'h0060;
  localparam logic [15:0] HOLD_RELEASE_RST  = 16'h0001;
  localparam logic [15:0] GENERIC_RST       = 16'h0000;
  localparam logic [15:0] CLK_OUT_ENABLE    = 16'h0005;
  localparam logic [15:0] LAUNCH_INTERNAL   = 16'h0002;

  localparam int unsigned RUN_BIT           = 0;
  localparam int unsigned LOCK_BIT          = 0;
  localparam int unsigned READ_FLAG_BIT     = 0;
  localparam logic [1:0]  SPI_SELECT_RISES  = 2'h3;
  localparam logic [3:0]  CMD_LAST_BIT      = 4'h7;
  localparam logic [3:0]  WORD_LAST_BIT     = 4'hF;

  // Synchronised pins: {ss_n, sclk, mosi, pll_lock}; select idles high.
  localparam int unsigned PIN_COUNT         = 4;
  localparam logic [3:0]  PIN_SYNC_RST      = 4'h8;

  localparam longint unsigned CLK_HZ             = 50_000_000;
  localparam longint unsigned LOCK_MAX_NS        = 10_666_000;
  localparam longint unsigned LOCK_MAX_CYC_CALC  =
    (LOCK_MAX_NS * CLK_HZ) / 1_000_000_000;
  localparam int unsigned     LOCK_MAX_CYC       = 533300;
  localparam int unsigned     LOCK_CNT_W         = 20;

  typedef enum logic [3:0] {
    DSC_IDLE = 4'h1,
    DSC_CMD  = 4'h2,
    DSC_ADDR = 4'h4,
    DSC_DATA = 4'h8
  } dsc_state_t;

  typedef struct packed {
    logic [15:0] feedback_div;
    logic [15:0] input_prescale;
    logic [15:0] clock_select;
    logic        pll_run;
    logic        clock_out_en;
    logic [15:0] power_a;
    logic [15:0] power_b;
    logic        core_sleep;
    logic        launch_internal;
    logic        core_run;
    logic [15:0] entry_point;
    logic        logic_hold;
    logic        page;
  } dsc_cfg_t;

  typedef struct packed {
    logic        strobe;
    logic        page;
    logic [15:0] addr;
    logic [15:0] data;
  } dsc_mem_wr_t;

endpackage

// ---- design/dsc_sync.sv ----
// Two flip-flop synchroniser for a group of pins.
module dsc_sync #(
  parameter int unsigned     W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ---- design/dsc_startup_config.sv ----
// Slave control port and startup configuration registers of the DSP.

// How it works
// R1: Host sleeps the core via the sleep register before bulk memory writes.
// R2: Host may use safeload for small parameter updates while core runs; this block has no safeload, such updates are direct memory writes.
// R3: Three rises of the select pin switch the slave port into SPI mode.
// R4: Host writes zero then one to the hold register to pulse soft reset.
// R5: Feedback divider resets to 96; host writes 96 during setup.
// R6: Host writes the prescale register to divide master clock by four.
// R7: Host writes one to clock select to choose the multiplied clock.
// R8: Value five in clock output setup enables the clock output pin.
// R9: Host sets the run register then waits up to 10.666 ms for lock.
// R10: Lock status bit 0 shows lock; host polls it until high.
// R11: While the multiplier tries to lock, all port writes are ignored.
// R12: Host writes 0x4FFF to subsystem power a.
// R13: Host writes zero to subsystem power b for unused subsystems.
// R14: Page select value zero reaches page 0, value one reaches page 1.
// R15: Memories at 0xC000, 0x0000, 0x6000 are written per page, lower first.
// R16: Host writes the program entry point after the download.
// R17: Value two in launch source selects the internal frame start pulse.
// R18: Host sets other nondefault registers before starting the core.
// R19: Run control zero halts the core; one starts execution.
// R20: Host waits 50 us after start before normal operation.
module dsc_startup_config
  import dsc_pkg::*;
#(
  parameter int unsigned LOCK_MAX = LOCK_MAX_CYC
) (
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire logic          slave_select_addr_pin_n,
  input  wire logic          spi_sclk,
  input  wire logic          spi_mosi,
  output logic               spi_miso_o,
  output logic               spi_miso_oe,
  input  wire logic          pll_lock_in,
  output logic               spi_mode,
  output logic               port_busy,
  output dsc_pkg::dsc_cfg_t  cfg,
  output dsc_pkg::dsc_mem_wr_t mem_wr
);
  import dsc_pkg::*;

  logic [PIN_COUNT-1:0]  pins_s;
  logic                  ss_n_s;
  logic                  sclk_s;
  logic                  mosi_s;
  logic                  lock_s;
  logic                  ss_prev_q;
  logic                  sclk_prev_q;
  logic                  ss_rise;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic [1:0]            ss_rises_q;
  logic                  spi_mode_q;
  dsc_state_t            state_q;
  logic [3:0]            bit_q;
  logic [15:0]           shift_q;
  logic [15:0]           shift_d;
  logic                  read_q;
  logic [15:0]           addr_q;
  logic [15:0]           tx_q;
  logic                  word_done;
  logic                  wr_en;
  logic                  lock_wait_q;
  logic [LOCK_CNT_W-1:0] lock_cnt_q;
  logic [15:0]           feedback_q;
  logic [15:0]           prescale_q;
  logic [15:0]           clk_sel_q;
  logic [15:0]           pll_run_q;
  logic [15:0]           clk_out_q;
  logic [15:0]           power_a_q;
  logic [15:0]           power_b_q;
  logic [15:0]           sleep_q;
  logic [15:0]           launch_q;
  logic [15:0]           run_ctl_q;
  logic [15:0]           entry_q;
  logic [15:0]           hold_q;
  logic [15:0]           page_q;
  dsc_sync #(
    .W       (PIN_COUNT),
    .RST_VAL (PIN_SYNC_RST)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d       ({slave_select_addr_pin_n, spi_sclk, spi_mosi, pll_lock_in}),
    .q       (pins_s)
  );
  assign ss_n_s    = pins_s[3];
  assign sclk_s    = pins_s[2];
  assign mosi_s    = pins_s[1];
  assign lock_s    = pins_s[0];
  assign ss_rise   = ss_n_s & ~ss_prev_q;
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign shift_d   = {shift_q[14:0], mosi_s};
  assign word_done = sclk_rise && !ss_n_s && state_q == DSC_DATA &&
                     bit_q == WORD_LAST_BIT;
  // Writes are dropped while the clock multiplier is locking.
  assign wr_en     = word_done && !read_q && !lock_wait_q; // R11

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ss_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      ss_prev_q   <= ss_n_s;
      sclk_prev_q <= sclk_s;
    end
  end

  // The port stays out of SPI mode until the third select rise.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ss_rises_q <= 2'h0;
      spi_mode_q <= 1'b0;
    end else if (!spi_mode_q && ss_rise) begin
      ss_rises_q <= ss_rises_q + 2'h1; // R3
      if (ss_rises_q + 2'h1 == SPI_SELECT_RISES) begin
        spi_mode_q <= 1'b1; // R3
      end
    end
  end

  function automatic logic [15:0] reg_read(input logic [15:0] a);
    case (a)
      ADDR_FEEDBACK_DIV: reg_read = feedback_q;
      ADDR_PRESCALE:     reg_read = prescale_q;
      ADDR_CLK_SELECT:   reg_read = clk_sel_q;
      ADDR_PLL_RUN:      reg_read = pll_run_q;
      ADDR_LOCK_STATUS:  reg_read = {15'h0000, lock_s}; // R10
      ADDR_CLK_OUT_CFG:  reg_read = clk_out_q;
      ADDR_POWER_A:      reg_read = power_a_q;
      ADDR_POWER_B:      reg_read = power_b_q;
      ADDR_CORE_SLEEP:   reg_read = sleep_q;
      ADDR_LAUNCH_SRC:   reg_read = launch_q;
      ADDR_RUN_CONTROL:  reg_read = run_ctl_q;
      ADDR_ENTRY_POINT:  reg_read = entry_q;
      ADDR_HOLD_RELEASE: reg_read = hold_q;
      ADDR_PAGE_SELECT:  reg_read = page_q;
      default:           reg_read = 16'h0000;
    endcase
  endfunction

  // Frame: command byte, 16-bit address, then 16-bit words that
  // auto-increment the address. Select high aborts the frame.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= DSC_IDLE;
      bit_q   <= 4'h0;
      shift_q <= 16'h0000;
      read_q  <= 1'b0;
      addr_q  <= 16'h0000;
    end else if (!spi_mode_q || ss_n_s) begin
      state_q <= DSC_IDLE;
      bit_q   <= 4'h0;
    end else begin
      case (state_q)
        DSC_IDLE: state_q <= DSC_CMD;
        DSC_CMD: begin
          if (sclk_rise) begin
            shift_q <= shift_d;
            bit_q   <= bit_q + 4'h1;
            if (bit_q == CMD_LAST_BIT) begin
              read_q  <= shift_d[READ_FLAG_BIT];
              bit_q   <= 4'h0;
              state_q <= DSC_ADDR;
            end
          end
        end
        DSC_ADDR, DSC_DATA: begin
          if (sclk_rise) begin
            shift_q <= shift_d;
            bit_q   <= bit_q + 4'h1;
            if (bit_q == WORD_LAST_BIT && state_q == DSC_ADDR) begin
              addr_q  <= shift_d;
              state_q <= DSC_DATA;
            end else if (bit_q == WORD_LAST_BIT) begin
              addr_q <= addr_q + 16'h0001;
            end
          end
        end
        default: state_q <= DSC_IDLE;
      endcase
    end
  end

  // Read data is loaded at each word start and shifted out on falls.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_q <= 16'h0000;
    end else if (sclk_rise && state_q == DSC_ADDR &&
                 bit_q == WORD_LAST_BIT) begin
      tx_q <= reg_read(shift_d);
    end else if (word_done) begin
      tx_q <= reg_read(addr_q + 16'h0001);
    end else if (sclk_fall && state_q == DSC_DATA && bit_q != 4'h0) begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  assign spi_miso_o  = tx_q[15];
  assign spi_miso_oe = spi_mode_q && !ss_n_s && state_q == DSC_DATA &&
                       read_q;

  // Lock wait opens on a run write and ends at lock or the longest time.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lock_wait_q <= 1'b0;
      lock_cnt_q  <= '0;
    end else if (wr_en && addr_q == ADDR_PLL_RUN && shift_d[RUN_BIT]) begin
      lock_wait_q <= 1'b1; // R9
      lock_cnt_q  <= '0;
    end else if (lock_wait_q) begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
      if (lock_s || lock_cnt_q == LOCK_CNT_W'(LOCK_MAX - 1)) begin
        lock_wait_q <= 1'b0; // R10
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      feedback_q <= FEEDBACK_DIV_RST; // R5
      prescale_q <= GENERIC_RST;
      clk_sel_q  <= GENERIC_RST;
      pll_run_q  <= GENERIC_RST;
      clk_out_q  <= GENERIC_RST;
      power_a_q  <= GENERIC_RST;
      power_b_q  <= GENERIC_RST;
      sleep_q    <= GENERIC_RST;
      launch_q   <= GENERIC_RST;
      run_ctl_q  <= GENERIC_RST;
      entry_q    <= GENERIC_RST;
      hold_q     <= HOLD_RELEASE_RST;
      page_q     <= GENERIC_RST;
    end else if (wr_en) begin
      case (addr_q)
        ADDR_FEEDBACK_DIV: feedback_q <= shift_d; // R5
        ADDR_PRESCALE:     prescale_q <= shift_d;
        ADDR_CLK_SELECT:   clk_sel_q  <= shift_d;
        ADDR_PLL_RUN:      pll_run_q  <= shift_d;
        ADDR_CLK_OUT_CFG:  clk_out_q  <= shift_d;
        ADDR_POWER_A:      power_a_q  <= shift_d;
        ADDR_POWER_B:      power_b_q  <= shift_d;
        ADDR_CORE_SLEEP:   sleep_q    <= shift_d;
        ADDR_LAUNCH_SRC:   launch_q   <= shift_d;
        ADDR_RUN_CONTROL:  run_ctl_q  <= shift_d; // R19
        ADDR_ENTRY_POINT:  entry_q    <= shift_d;
        ADDR_HOLD_RELEASE: hold_q     <= shift_d;
        ADDR_PAGE_SELECT:  page_q     <= shift_d; // R14
        default: ;
      endcase
    end
  end

  // Memory words below the register space go out with the page tag.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_wr <= '0;
    end else begin
      mem_wr.strobe <= wr_en && addr_q < ADDR_REG_BASE; // R15
      if (wr_en && addr_q < ADDR_REG_BASE) begin
        mem_wr.page <= page_q[0]; // R14
        mem_wr.addr <= addr_q;
        mem_wr.data <= shift_d;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg <= '0;
      cfg.feedback_div <= FEEDBACK_DIV_RST;
    end else begin
      cfg.feedback_div    <= feedback_q;
      cfg.input_prescale  <= prescale_q;
      cfg.clock_select    <= clk_sel_q;
      cfg.pll_run         <= pll_run_q[RUN_BIT];
      cfg.clock_out_en    <= clk_out_q == CLK_OUT_ENABLE; // R8
      cfg.power_a         <= power_a_q;
      cfg.power_b         <= power_b_q;
      cfg.core_sleep      <= sleep_q[RUN_BIT];
      cfg.launch_internal <= launch_q == LAUNCH_INTERNAL; // R17
      cfg.core_run        <= run_ctl_q[RUN_BIT]; // R19
      cfg.entry_point     <= entry_q;
      cfg.logic_hold      <= ~hold_q[RUN_BIT];
      cfg.page            <= page_q[0]; // R14
    end
  end

  assign spi_mode  = spi_mode_q;
  assign port_busy = lock_wait_q;
endmodule

// ---- tb/dsc_startup_monitor.sv ----
// Port-level checker for the startup configuration block.
module dsc_startup_monitor
  import dsc_pkg::*;
#(
  parameter int unsigned LOCK_MAX = LOCK_MAX_CYC
) (
  input wire logic                 clk_sys,
  input wire logic                 reset,
  input wire logic                 slave_select_addr_pin_n,
  input wire logic                 spi_sclk,
  input wire logic                 spi_mosi,
  input wire logic                 spi_miso_o,
  input wire logic                 spi_miso_oe,
  input wire logic                 pll_lock_in,
  input wire logic                 spi_mode,
  input wire logic                 port_busy,
  input wire dsc_pkg::dsc_cfg_t    cfg,
  input wire dsc_pkg::dsc_mem_wr_t mem_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [LOCK_CNT_W-1:0] busy_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (reset || !port_busy) busy_cnt_q <= '0;
    else busy_cnt_q <= busy_cnt_q + 1'b1;
  end
  a_reset_values: assert property (disable iff (1'b0) reset[*3] |=>
    cfg.feedback_div == 16'h0060 && !spi_mode && !port_busy)
    else $error("reset values wrong");
  a_mode_sticky: assert property (spi_mode |=> spi_mode)
    else $error("spi mode dropped");
  a_mode_entry: assert property ($rose(spi_mode) |->
    slave_select_addr_pin_n && $past(slave_select_addr_pin_n))
    else $error("spi mode without select rise");
  a_oe_mode: assert property (spi_miso_oe |-> spi_mode)
    else $error("data out driven outside spi mode");
  a_busy_cause: assert property ($rose(port_busy) |=> cfg.pll_run)
    else $error("busy without run request");
  a_busy_bound: assert property (busy_cnt_q <= LOCK_CNT_W'(LOCK_MAX + 2))
    else $error("lock wait too long");
  a_lock_ends: assert property (pll_lock_in[*4] ##0 port_busy
    |=> !port_busy)
    else $error("busy stays after lock");
  a_busy_blocks: assert property (port_busy && $past(port_busy)
    |-> $stable(cfg.input_prescale) && $stable(cfg.power_a))
    else $error("write taken during lock wait");
  a_strobe_pulse: assert property (mem_wr.strobe |=> !mem_wr.strobe)
    else $error("memory strobe longer than one cycle");
  a_strobe_addr: assert property (mem_wr.strobe |->
    mem_wr.addr < 16'hF000)
    else $error("memory strobe on register address");
  c_mode: cover property ($rose(spi_mode));
  c_busy: cover property ($rose(port_busy));
  c_page1: cover property (mem_wr.strobe && mem_wr.page);
  c_run: cover property ($rose(cfg.core_run));
endmodule

bind dsc_startup_config dsc_startup_monitor #(.LOCK_MAX(LOCK_MAX)) u_monitor (
  .clk_sys(clk_sys), .reset(reset),
  .slave_select_addr_pin_n(slave_select_addr_pin_n),
  .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
  .spi_miso_oe(spi_miso_oe), .pll_lock_in(pll_lock_in),
  .spi_mode(spi_mode), .port_busy(port_busy), .cfg(cfg), .mem_wr(mem_wr));

// ---- tb/dsc_host_model.sv ----
// Host model acting as SPI master on the slave control port.
module dsc_host_model (
  input  wire logic clk_sys,
  input  wire logic miso,
  output logic      slave_select_n,
  output logic      sclk,
  output logic      mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    slave_select_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Three select pulses, each several clocks long, switch to SPI.
  task automatic select_spi();
    repeat (3) begin
      idle(4);
      slave_select_n = 1'b0;
      idle(4);
      slave_select_n = 1'b1;
    end
    idle(4);
  endtask
  // Data is set while the clock is low and read as it rises.
  task automatic shift(input logic [15:0] v, input int n,
                       output logic [15:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = v[i];
      idle(8);
      sclk = 1'b1;
      r = {r[14:0], miso};
      idle(8);
      sclk = 1'b0;
    end
  endtask
  task automatic frame(input logic rd, input logic [15:0] a,
                       input logic [15:0] d, output logic [15:0] r);
    logic [15:0] x;
    idle(1);
    slave_select_n = 1'b0;
    idle(4);
    shift({15'h0000, rd}, 8, x);
    shift(a, 16, x);
    shift(d, 16, r);
    idle(8);
    slave_select_n = 1'b1;
    idle(8);
  endtask
endmodule

// ---- tb/dsc_startup_config_tb.sv ----
// Self-checking testbench for the startup configuration block.
module dsc_startup_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dsc_pkg::*;
  localparam logic [31:0] TAB [12] = '{
    32'hF890_0000, 32'hF890_0001, 32'hF000_0060, 32'hF001_0002,
    32'hF002_0001, 32'hF005_0005, 32'hF050_4FFF, 32'hF051_0000,
    32'hF400_0001, 32'hF400_0000, 32'hF404_0000, 32'hF401_0002};
  localparam logic [15:0] MEM [3] = '{16'hC000, 16'h0000, 16'h6000};
  logic        clk_sys;
  logic        reset;
  logic        lock_pin;
  logic        ss_n;
  logic        sclk;
  logic        mosi;
  logic        miso_o;
  logic        miso_oe;
  logic        miso_w;
  logic        spi_mode;
  logic        port_busy;
  logic [15:0] r;
  int          n_errors;
  int          tests_run;
  int          cyc = 0;
  dsc_cfg_t    cfg;
  dsc_mem_wr_t mem_wr;
  dsc_mem_wr_t seen;
  // A released data line shows a changing pattern, never a held value.
  assign miso_w = miso_oe ? miso_o : cyc[0];
  dsc_startup_config #(.LOCK_MAX(5000)) dut (
    .clk_sys(clk_sys), .reset(reset), .slave_select_addr_pin_n(ss_n),
    .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso_o(miso_o),
    .spi_miso_oe(miso_oe), .pll_lock_in(lock_pin), .spi_mode(spi_mode),
    .port_busy(port_busy), .cfg(cfg), .mem_wr(mem_wr));
  dsc_host_model u_host (
    .clk_sys(clk_sys), .miso(miso_w), .slave_select_n(ss_n),
    .sclk(sclk), .mosi(mosi));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (mem_wr.strobe === 1'b1) seen <= mem_wr;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_host.frame(1'b0, a, d, r);
  endtask
  task automatic rd(input logic [15:0] a);
    u_host.frame(1'b1, a, 16'h0000, r);
  endtask
  // Writes each table entry and reads it back.
  task automatic run_tab(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      wr(TAB[i][31:16], TAB[i][15:0]);
      rd(TAB[i][31:16]);
      check(r, TAB[i][15:0]);
    end
  endtask
  task automatic run_tests();
    reset = 1'b1;
    lock_pin = 1'b0;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    u_host.idle(4);
    wr(ADDR_CLK_OUT_CFG, CLK_OUT_ENABLE);
    check(cfg.clock_out_en, 16'h0000);
    check(spi_mode, 16'h0000);
    u_host.select_spi();
    check(spi_mode, 16'h0001);
    rd(ADDR_FEEDBACK_DIV);
    check(r, FEEDBACK_DIV_RST);
    rd(ADDR_HOLD_RELEASE);
    check(r, HOLD_RELEASE_RST);
    rd(ADDR_CORE_SLEEP);
    check(r, GENERIC_RST);
    rd(16'hF7FF);
    check(r, 16'h0000);
    run_tab(0, 5);
    check(cfg.clock_out_en, 16'h0001);
    check(cfg.input_prescale, 16'h0002);
    check(cfg.clock_select, 16'h0001);
    check(cfg.logic_hold, 16'h0000);
    wr(ADDR_CLK_OUT_CFG, 16'h0004);
    check(cfg.clock_out_en, 16'h0000);
    wr(ADDR_CLK_OUT_CFG, CLK_OUT_ENABLE);
    wr(ADDR_PLL_RUN, 16'h0001);
    check(port_busy, 16'h0001);
    check(cfg.pll_run, 16'h0001);
    wr(ADDR_PRESCALE, 16'h0007);
    rd(ADDR_PRESCALE);
    check(r, 16'h0002);
    rd(ADDR_LOCK_STATUS);
    check(r, 16'h0000);
    lock_pin = 1'b1;
    for (int i = 0; i < 20 && port_busy !== 1'b0; i++) u_host.idle(1);
    check(port_busy, 16'h0000);
    rd(ADDR_LOCK_STATUS);
    check(r, 16'h0001);
    // With no lock the wait must still end after the longest lock time.
    lock_pin = 1'b0;
    wr(ADDR_PLL_RUN, 16'h0001);
    check(port_busy, 16'h0001);
    u_host.idle(5010);
    check(port_busy, 16'h0000);
    lock_pin = 1'b1;
    run_tab(6, 8);
    check(cfg.power_a, 16'h4FFF);
    check(cfg.power_b, 16'h0000);
    check(cfg.core_sleep, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_PAGE_SELECT, p[15:0]);
      check(cfg.page, p[0]);
      for (int m = 0; m < 3; m++) begin
        wr(MEM[m], 16'h5A00 + 16'(p * 3 + m));
        check(seen.addr, MEM[m]);
        check(seen.data, 16'h5A00 + 16'(p * 3 + m));
        check(seen.page, p[0]);
      end
    end
    run_tab(9, 11);
    check(cfg.launch_internal, 16'h0001);
    check(cfg.core_sleep, 16'h0000);
    wr(ADDR_RUN_CONTROL, 16'h0000);
    check(cfg.core_run, 16'h0000);
    wr(ADDR_RUN_CONTROL, 16'h0001);
    check(cfg.core_run, 16'h0001);
    // A small parameter update lands while the core keeps running.
    wr(ADDR_DATA_MEM1, 16'h1234);
    check(seen.data, 16'h1234);
    check(cfg.core_run, 16'h0001);
    u_host.idle(2500);
    reset = 1'b1;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    u_host.idle(4);
    check(spi_mode, 16'h0000);
    check(cfg.core_run, 16'h0000);
    check(cfg.feedback_div, FEEDBACK_DIV_RST);
  endtask
  initial begin
    n_errors = 0;
    tests_run = 0;
    fork
      run_tests();
      wait (cyc == 80000);
    join_any
    if (cyc >= 80000) n_errors++;
    wrap_up();
  end
endmodule
